/* nmf_regs.sv */
// network mode filter register bank with per-packet reply and drop decisions
// assumes host register strobes and packet classifier events come from clk's domain
module nmf_regs
  import nmf_pkg::*;
#(
  parameter int LCP_UNIT_CYC = NMF_LCP_UNIT_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // host register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output      logic [7:0]  reg_rdata,
  output      logic        reg_rvalid,
  // packet classifier events, one-cycle pulses
  input  wire logic        rx_ipv4_pkt,
  input  wire logic        rx_ipv6_pkt,
  input  wire logic        rx_udp6_closed,
  input  wire logic        rx_syn6_no_listen,
  input  wire logic        rx_ping6_req,
  input  wire logic        rx_ping6_all_nodes,
  input  wire logic        rx_ping6_mcast,
  // decisions, one-cycle pulses
  output      logic        ipv4_drop,
  output      logic        ipv6_drop,
  output      logic        unreach6_send,
  output      logic        tcp_rst6_send,
  output      logic        ping6_reply_send,
  output      logic        ping6_resolve_first,
  output      logic        lcp_echo_req,
  // mode levels
  output      logic        wake_on_lan_enable,
  output      logic        dest_hw_addr_select,
  output      logic        pppoe_enable,
  output      logic [31:0] lcp_magic_number
);

  logic [7:0]  ipv6_option_control_q;
  logic [7:0]  global_network_mode_q;
  logic [7:0]  network_mode_second_q;
  logic [7:0]  lcp_echo_interval_q;
  logic [7:0]  lcp_magic_byte_q;
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  logic [31:0] magic_q;
  logic        v4_drop_q;
  logic        v6_drop_q;
  logic        unreach_q;
  logic        rst_q;
  logic        reply_q;
  logic        resolve_q;
  logic        echo_q;
  nmf_reg_sel_t wr_sel;

  nmf_lcp_if lcp ();

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic nmf_reg_sel_t decode(input logic [15:0] a);
    if (a == NMF_OFS_IPV6_OPT) begin
      decode = NMF_REG_IPV6_OPT;
    end else if (a == NMF_OFS_GLOBAL_MODE) begin
      decode = NMF_REG_GLOBAL_MODE;
    end else if (a == NMF_OFS_MODE_SECOND) begin
      decode = NMF_REG_MODE_SECOND;
    end else if (a == NMF_OFS_LCP_ECHO) begin
      decode = NMF_REG_LCP_ECHO;
    end else if (a == NMF_OFS_LCP_MAGIC) begin
      decode = NMF_REG_LCP_MAGIC;
    end else begin
      decode = NMF_REG_NONE;
    end
  endfunction

  assign wr_sel = decode(reg_addr);

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // reserved bits are masked off so a careless host cannot set them
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ipv6_option_control_q <= NMF_RST_IPV6_OPT;
      global_network_mode_q <= NMF_RST_GLOBAL_MODE;
      network_mode_second_q <= NMF_RST_MODE_SECOND;
      lcp_echo_interval_q   <= NMF_RST_LCP_ECHO;
      lcp_magic_byte_q      <= NMF_RST_LCP_MAGIC;
    end else if (reg_wr) begin
      case (wr_sel)
        NMF_REG_IPV6_OPT: begin
          ipv6_option_control_q <= reg_wdata & NMF_MSK_IPV6_OPT;
        end
        NMF_REG_GLOBAL_MODE: begin
          global_network_mode_q <= reg_wdata & NMF_MSK_GLOBAL_MODE;
        end
        NMF_REG_MODE_SECOND: begin
          network_mode_second_q <= reg_wdata & NMF_MSK_MODE_SECOND;
        end
        NMF_REG_LCP_ECHO: begin
          lcp_echo_interval_q <= reg_wdata;
        end
        NMF_REG_LCP_MAGIC: begin
          lcp_magic_byte_q <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  // unmapped addresses read as zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        case (decode(reg_addr))
          NMF_REG_IPV6_OPT:    rdata_q <= ipv6_option_control_q;
          NMF_REG_GLOBAL_MODE: rdata_q <= global_network_mode_q;
          NMF_REG_MODE_SECOND: rdata_q <= network_mode_second_q;
          NMF_REG_LCP_ECHO:    rdata_q <= lcp_echo_interval_q;
          NMF_REG_LCP_MAGIC:   rdata_q <= lcp_magic_byte_q;
          default:             rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // traffic and reply decisions
  // ---------------------------------------------------------------
  logic ipv6_traffic_block;
  logic ping_ok;

  assign ipv6_traffic_block    = global_network_mode_q[NMF_B_IPV6_BLOCK];
  // ipv6 block overrides the finer ping filters, they only matter when it is clear
  assign ping_ok = rx_ping6_req && !ipv6_traffic_block
                   && !ipv6_option_control_q[NMF_B_PING_BLOCK]
                   && !(rx_ping6_all_nodes && global_network_mode_q[NMF_B_ALL_NODES_BLK])
                   && !(rx_ping6_mcast && global_network_mode_q[NMF_B_MCAST_BLK]);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      v4_drop_q <= 1'b0;
      v6_drop_q <= 1'b0;
    end else begin
      v4_drop_q <= rx_ipv4_pkt && global_network_mode_q[NMF_B_IPV4_BLOCK];
      v6_drop_q <= rx_ipv6_pkt && ipv6_traffic_block;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unreach_q <= 1'b0;
      rst_q     <= 1'b0;
    end else begin
      unreach_q <= rx_udp6_closed && !ipv6_traffic_block
                   && !ipv6_option_control_q[NMF_B_UNREACH_BLOCK];
      rst_q     <= rx_syn6_no_listen && !ipv6_traffic_block
                   && !ipv6_option_control_q[NMF_B_TCP_RST_BLOCK];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reply_q   <= 1'b0;
      resolve_q <= 1'b0;
    end else begin
      reply_q   <= ping_ok;
      resolve_q <= ping_ok && ipv6_option_control_q[NMF_B_RESOLVE_PING];
    end
  end

  // ---------------------------------------------------------------
  // pppoe lcp: magic number and echo timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      magic_q <= 32'h0000_0000;
      echo_q  <= 1'b0;
    end else begin
      magic_q <= network_mode_second_q[NMF_B_PPPOE_EN]
                 ? {4{lcp_magic_byte_q}} : 32'h0000_0000;
      echo_q  <= lcp.echo_pulse;
    end
  end

  assign lcp.enable   = network_mode_second_q[NMF_B_PPPOE_EN];
  assign lcp.interval = lcp_echo_interval_q;

  nmf_lcp_timer #(
    .UNIT_CYC (LCP_UNIT_CYC)
  ) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .lcp     (lcp.timer)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata           = rdata_q;
  assign reg_rvalid          = rvalid_q;
  assign ipv4_drop           = v4_drop_q;
  assign ipv6_drop           = v6_drop_q;
  assign unreach6_send       = unreach_q;
  assign tcp_rst6_send       = rst_q;
  assign ping6_reply_send    = reply_q;
  assign ping6_resolve_first = resolve_q;
  assign lcp_echo_req        = echo_q;
  assign wake_on_lan_enable  = global_network_mode_q[NMF_B_WAKE_ON_LAN];
  assign dest_hw_addr_select = network_mode_second_q[NMF_B_DEST_HW_SEL];
  assign pppoe_enable        = network_mode_second_q[NMF_B_PPPOE_EN];
  assign lcp_magic_number    = magic_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_write_global;
    reg_wr && wr_sel == NMF_REG_GLOBAL_MODE;
  endsequence

  sequence s_read_ipv6;
    reg_rd && decode(reg_addr) == NMF_REG_IPV6_OPT;
  endsequence

  unreach_block_a: assert property (
    rx_udp6_closed |=> unreach6_send == $past(!ipv6_option_control_q[3] && !global_network_mode_q[1]))
    else $error("udp6 unreachable reply disagrees with block bits");

  resolve_first_a: assert property (
    ping6_resolve_first |-> ping6_reply_send && $past(ipv6_option_control_q[2]))
    else $error("neighbour resolve flagged without reply or enable");

  tcp_rst_block_a: assert property (
    rx_syn6_no_listen && ipv6_option_control_q[1] |=> !tcp_rst6_send)
    else $error("tcp reset sent while blocked");

  ping_block_a: assert property (
    ping6_reply_send |-> $past(rx_ping6_req) && !$past(ipv6_option_control_q[0]))
    else $error("ping6 reply sent while blocked or unrequested");

  all_nodes_a: assert property (
    rx_ping6_req && rx_ping6_all_nodes && global_network_mode_q[5] |=> !ping6_reply_send)
    else $error("all-nodes ping6 answered while blocked");

  mcast_ping_a: assert property (
    rx_ping6_req && rx_ping6_mcast && global_network_mode_q[4] |=> !ping6_reply_send)
    else $error("multicast ping6 answered while blocked");

  wol_follow_a: assert property (
    s_write_global ##1 !reg_wr |-> wake_on_lan_enable == $past(reg_wdata[2]))
    else $error("wake-on-lan enable does not follow write");

  ipv6_override_a: assert property (
    rx_ipv6_pkt && rx_ping6_req && global_network_mode_q[1] |=> ipv6_drop && !ping6_reply_send)
    else $error("ipv6 block did not override ping filters");

  ipv4_drop_a: assert property (
    rx_ipv4_pkt |=> ipv4_drop == $past(global_network_mode_q[0]))
    else $error("ipv4 drop disagrees with block bit");

  magic_repl_a: assert property (
    pppoe_enable |=> lcp_magic_number == {4{$past(lcp_magic_byte_q)}})
    else $error("lcp magic number not replicated byte");

  magic_gate_a: assert property (
    !pppoe_enable [*3] |-> lcp_magic_number == 32'h0000_0000 && !lcp_echo_req)
    else $error("lcp settings active outside pppoe");

  readback_a: assert property (
    s_read_ipv6 |=> reg_rvalid && reg_rdata == $past(ipv6_option_control_q) && reg_rdata[7:4] == 4'h0)
    else $error("ipv6 option readback wrong");

endmodule

/* nmf_pkg.sv */
// network mode filter package: register map, field positions, reset values, timing
// assumes a single 250 MHz system clock shared by every user of these constants
package nmf_pkg;

  // ---------------------------------------------------------------
  // register offsets (host byte addresses)
  // ---------------------------------------------------------------
  localparam logic [15:0] NMF_OFS_IPV6_OPT    = 16'h4004;
  localparam logic [15:0] NMF_OFS_GLOBAL_MODE = 16'h4008;
  localparam logic [15:0] NMF_OFS_MODE_SECOND = 16'h4009;
  localparam logic [15:0] NMF_OFS_LCP_ECHO    = 16'h4100;
  localparam logic [15:0] NMF_OFS_LCP_MAGIC   = 16'h4104;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] NMF_RST_IPV6_OPT    = 8'h00;
  localparam logic [7:0] NMF_RST_GLOBAL_MODE = 8'h00;
  localparam logic [7:0] NMF_RST_MODE_SECOND = 8'h00;
  localparam logic [7:0] NMF_RST_LCP_ECHO    = 8'h28;
  localparam logic [7:0] NMF_RST_LCP_MAGIC   = 8'h00;

  // ---------------------------------------------------------------
  // writable-bit masks, reserved bits stay zero
  // ---------------------------------------------------------------
  localparam logic [7:0] NMF_MSK_IPV6_OPT    = 8'h0F;
  localparam logic [7:0] NMF_MSK_GLOBAL_MODE = 8'h37;
  localparam logic [7:0] NMF_MSK_MODE_SECOND = 8'h81;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int NMF_B_UNREACH_BLOCK = 3;
  localparam int NMF_B_RESOLVE_PING  = 2;
  localparam int NMF_B_TCP_RST_BLOCK = 1;
  localparam int NMF_B_PING_BLOCK    = 0;
  localparam int NMF_B_ALL_NODES_BLK = 5;
  localparam int NMF_B_MCAST_BLK     = 4;
  localparam int NMF_B_WAKE_ON_LAN   = 2;
  localparam int NMF_B_IPV6_BLOCK    = 1;
  localparam int NMF_B_IPV4_BLOCK    = 0;
  localparam int NMF_B_DEST_HW_SEL   = 7;
  localparam int NMF_B_PPPOE_EN      = 0;

  // ---------------------------------------------------------------
  // lcp echo timing
  // ---------------------------------------------------------------
  localparam int NMF_CLK_KHZ        = 250000;
  localparam int NMF_LCP_UNIT_MS    = 25;
  localparam int NMF_LCP_UNIT_CYC   = NMF_LCP_UNIT_MS * NMF_CLK_KHZ;

  typedef enum logic [2:0] {
    NMF_REG_IPV6_OPT,
    NMF_REG_GLOBAL_MODE,
    NMF_REG_MODE_SECOND,
    NMF_REG_LCP_ECHO,
    NMF_REG_LCP_MAGIC,
    NMF_REG_NONE
  } nmf_reg_sel_t;

endpackage

/* nmf_lcp_if.sv */
// lcp echo control link between the register bank and its interval timer
// assumes both ends sit on the same clock
interface nmf_lcp_if;
  logic       enable;
  logic [7:0] interval;
  logic       echo_pulse;

  modport ctrl  (output enable, output interval, input echo_pulse);
  modport timer (input enable, input interval, output echo_pulse);
endinterface

/* nmf_lcp_timer.sv */
// lcp echo request interval timer: one pulse every interval x 25 ms units
// assumes clk at 250 MHz and a synchronous enable from the register bank
module nmf_lcp_timer
  import nmf_pkg::*;
#(
  parameter int UNIT_CYC = NMF_LCP_UNIT_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control link
  nmf_lcp_if.timer  lcp
);

  logic [31:0] unit_cnt_q;
  logic [7:0]  tick_cnt_q;
  logic        echo_q;
  logic        unit_end;

  assign unit_end = (unit_cnt_q == 32'(UNIT_CYC - 1));

  // ---------------------------------------------------------------
  // 25 ms prescaler and unit counter
  // ---------------------------------------------------------------
  // idle when pppoe is off so the first echo is a full interval after enable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unit_cnt_q <= 32'h0;
      tick_cnt_q <= 8'h00;
    end else if (!lcp.enable) begin
      unit_cnt_q <= 32'h0;
      tick_cnt_q <= 8'h00;
    end else if (unit_end) begin
      unit_cnt_q <= 32'h0;
      if (tick_cnt_q + 8'h01 >= lcp.interval) begin
        tick_cnt_q <= 8'h00;
      end else begin
        tick_cnt_q <= tick_cnt_q + 8'h01;
      end
    end else begin
      unit_cnt_q <= unit_cnt_q + 32'h1;
    end
  end

  // a zero interval never fires
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      echo_q <= 1'b0;
    end else begin
      echo_q <= lcp.enable && unit_end && (lcp.interval != 8'h00)
                && (tick_cnt_q + 8'h01 >= lcp.interval);
    end
  end

  assign lcp.echo_pulse = echo_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  echo_only_pppoe_a: assert property (@(posedge clk) disable iff (sys_rst)
    echo_q |-> $past(lcp.enable))
    else $error("lcp echo fired while pppoe disabled");

  echo_on_unit_a: assert property (@(posedge clk) disable iff (sys_rst)
    echo_q |-> $past(unit_end) && $past(lcp.interval) != 8'h00
               && $past(tick_cnt_q) + 8'h01 >= $past(lcp.interval))
    else $error("lcp echo fired off its interval boundary");

endmodule

/* nmf_peer_model.sv */
// network peer model: turns a received-packet kind into classifier event pulses
// assumes the bench changes the kind on the falling edge and holds it one cycle
module nmf_peer_model (
  // kind: [6] ipv4 [5] ipv6 [4] udp6 closed [3] syn6 [2] ping6 [1] all-nodes [0] mcast
  input  wire logic [6:0] pkt_kind,
  // events towards the classifier inputs, same bit order
  output      logic [6:0] rx_ev
);
  timeunit 1ns;
  timeprecision 100ps;

  // -----------------------------------------------------------------
  // event lines
  // -----------------------------------------------------------------
  // qualifiers mean nothing without a ping, so they show no useful value then
  always_comb begin
    rx_ev = pkt_kind;
    if (!pkt_kind[2]) begin
      rx_ev[1:0] = ~pkt_kind[1:0];
    end
  end
endmodule

/* nmf_regs_tb.sv */
// self-checking bench for the network mode filter register bank
// assumes nmf_pkg and the peer model are compiled first; timer unit shortened
module nmf_regs_tb
  import nmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int UNIT = 10;

  logic        clk;
  logic        sys_rst;
  logic [15:0] reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [6:0]  rx_ev;
  logic [6:0]  pkt_kind;
  logic        ipv4_drop;
  logic        ipv6_drop;
  logic        unreach6_send;
  logic        tcp_rst6_send;
  logic        ping6_reply_send;
  logic        ping6_resolve_first;
  logic        lcp_echo_req;
  logic        wake_on_lan_enable;
  logic        dest_hw_addr_select;
  logic        pppoe_enable;
  logic [31:0] lcp_magic_number;
  int          failures;
  int          checks_done;

  nmf_regs #(.LCP_UNIT_CYC(UNIT)) DUT (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .rx_ipv4_pkt(rx_ev[6]), .rx_ipv6_pkt(rx_ev[5]), .rx_udp6_closed(rx_ev[4]),
    .rx_syn6_no_listen(rx_ev[3]), .rx_ping6_req(rx_ev[2]), .rx_ping6_all_nodes(rx_ev[1]),
    .rx_ping6_mcast(rx_ev[0]), .ipv4_drop(ipv4_drop), .ipv6_drop(ipv6_drop),
    .unreach6_send(unreach6_send), .tcp_rst6_send(tcp_rst6_send),
    .ping6_reply_send(ping6_reply_send), .ping6_resolve_first(ping6_resolve_first),
    .lcp_echo_req(lcp_echo_req), .wake_on_lan_enable(wake_on_lan_enable),
    .dest_hw_addr_select(dest_hw_addr_select), .pppoe_enable(pppoe_enable),
    .lcp_magic_number(lcp_magic_number)
  );

  nmf_peer_model peer (.pkt_kind(pkt_kind), .rx_ev(rx_ev));

  always #2 clk = ~clk;

  // -----------------------------------------------------------------
  // shared helpers
  // -----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk_bit(input logic seen, input logic exp);
    check({31'h00000000, seen}, {31'h00000000, exp});
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
  endtask

  task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
    int i;
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    // bounded wait so a missing valid shows up as a mismatch, not a hang
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge clk);
    chk_bit(reg_rvalid, 1'b1);
    d = reg_rdata;
  endtask

  task automatic chk_reg(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_read(a, d);
    check({24'h000000, d}, {24'h000000, e});
  endtask

  task automatic count_echo(input int span, output int n);
    n = 0;
    repeat (span) begin
      @(negedge clk);
      if (lcp_echo_req === 1'b1) n++;
    end
  endtask

  // one packet kind for one cycle, then idle
  task automatic send(input logic [6:0] ev);
    @(negedge clk);
    pkt_kind = ev;
    @(negedge clk);
    pkt_kind = 7'h00;
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic test_reset_values();
    chk_reg(NMF_OFS_IPV6_OPT, 8'h00);
    chk_reg(NMF_OFS_GLOBAL_MODE, 8'h00);
    chk_reg(NMF_OFS_MODE_SECOND, 8'h00);
    chk_reg(NMF_OFS_LCP_ECHO, 8'h28);
    chk_reg(NMF_OFS_LCP_MAGIC, 8'h00);
    chk_bit(pppoe_enable, 1'b0);
  endtask

  task automatic test_regs();
    reg_write(NMF_OFS_IPV6_OPT, 8'hFF);
    chk_reg(NMF_OFS_IPV6_OPT, 8'h0F);
    reg_write(NMF_OFS_GLOBAL_MODE, 8'h37);
    chk_bit(wake_on_lan_enable, 1'b1);
    chk_reg(NMF_OFS_GLOBAL_MODE, 8'h37);
    reg_write(NMF_OFS_GLOBAL_MODE, 8'h00);
    chk_bit(wake_on_lan_enable, 1'b0);
    reg_write(NMF_OFS_MODE_SECOND, 8'hFF);
    chk_bit(dest_hw_addr_select, 1'b1);
    chk_bit(pppoe_enable, 1'b1);
    chk_reg(NMF_OFS_MODE_SECOND, 8'h81);
    reg_write(NMF_OFS_MODE_SECOND, 8'h00);
    chk_bit(dest_hw_addr_select, 1'b0);
    chk_bit(pppoe_enable, 1'b0);
    reg_write(NMF_OFS_LCP_ECHO, 8'hA5);
    chk_reg(NMF_OFS_LCP_ECHO, 8'hA5);
    reg_write(NMF_OFS_LCP_MAGIC, 8'h3C);
    chk_reg(NMF_OFS_LCP_MAGIC, 8'h3C);
    reg_write(16'h4005, 8'hFF);
    chk_reg(16'h4005, 8'h00);
    chk_reg(NMF_OFS_IPV6_OPT, 8'h0F);
  endtask

  task automatic test_ipv6_options();
    logic [7:0] o;
    for (int i = 0; i < 16; i++) begin
      o = 8'(i);
      reg_write(NMF_OFS_IPV6_OPT, o);
      send(7'h30);
      chk_bit(unreach6_send, ~o[3]);
      send(7'h28);
      chk_bit(tcp_rst6_send, ~o[1]);
      send(7'h24);
      chk_bit(ping6_reply_send, ~o[0]);
      chk_bit(ping6_resolve_first, ~o[0] & o[2]);
    end
    reg_write(NMF_OFS_IPV6_OPT, 8'h00);
  endtask

  task automatic test_global_blocks();
    logic [7:0] tab [8] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h02, 8'h32, 8'h01, 8'h33};
    logic [7:0] g;
    for (int i = 0; i < 8; i++) begin
      g = tab[i];
      reg_write(NMF_OFS_GLOBAL_MODE, g);
      send(7'h26);
      chk_bit(ping6_reply_send, ~g[1] & ~g[5]);
      chk_bit(ipv6_drop, g[1]);
      send(7'h25);
      chk_bit(ping6_reply_send, ~g[1] & ~g[4]);
      send(7'h24);
      chk_bit(ping6_reply_send, ~g[1]);
      send(7'h40);
      chk_bit(ipv4_drop, g[0]);
      chk_bit(ipv6_drop, 1'b0);
    end
    reg_write(NMF_OFS_GLOBAL_MODE, 8'h00);
  endtask

  task automatic test_lcp();
    int n;
    reg_write(NMF_OFS_LCP_ECHO, 8'h03);
    reg_write(NMF_OFS_LCP_MAGIC, 8'h5A);
    check(lcp_magic_number, 32'h00000000);
    count_echo(50, n);
    check(32'(n), 32'h00000000);
    reg_write(NMF_OFS_MODE_SECOND, 8'h01);
    // magic number is registered behind the mode bit: one more cycle
    @(negedge clk);
    check(lcp_magic_number, 32'h5A5A5A5A);
    // first pulse: allow the start-up pipeline slack
    for (n = 0; n < 3 * UNIT + 10 && lcp_echo_req !== 1'b1; n++) @(negedge clk);
    chk_bit(lcp_echo_req, 1'b1);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (lcp_echo_req !== 1'b1 && n < 200);
    check(32'(n), 32'(3 * UNIT));
    reg_write(NMF_OFS_MODE_SECOND, 8'h00);
    @(negedge clk);
    check(lcp_magic_number, 32'h00000000);
    count_echo(80, n);
    check(32'(n), 32'h00000000);
  endtask

  // reset in mid-run must bring configured registers back to their reset values
  task automatic test_mid_reset();
    reg_write(NMF_OFS_GLOBAL_MODE, 8'h04);
    chk_bit(wake_on_lan_enable, 1'b1);
    @(negedge clk);
    sys_rst = 1'b1;
    @(negedge clk);
    chk_bit(wake_on_lan_enable, 1'b0);
    sys_rst = 1'b0;
    chk_reg(NMF_OFS_IPV6_OPT, 8'h00);
    chk_reg(NMF_OFS_LCP_ECHO, 8'h28);
    chk_reg(NMF_OFS_LCP_MAGIC, 8'h00);
  endtask

  // -----------------------------------------------------------------
  // run control
  // -----------------------------------------------------------------
  task automatic complete_run();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    // whole run needs about 500 cycles; allow forty times that
    #80000;
    failures++;
    complete_run();
  end

  initial begin
    clk       = 1'b0;
    sys_rst   = 1'b1;
    reg_addr  = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
    pkt_kind  = 7'h00;
    failures    = 0;
    checks_done = 0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    test_reset_values();
    test_regs();
    test_mid_reset();
    test_ipv6_options();
    test_global_blocks();
    test_lcp();
    complete_run();
  end
endmodule
